// [include/rvad_pkg.sv]
// constants and types shared by the rom-variant address decoder
package rvad_pkg;
  // ==========================================================
  // memory map, cpu byte addresses
  localparam logic [15:0] IO_LO    = 16'h0000;
  localparam logic [15:0] IO_HI    = 16'h003F;
  localparam logic [15:0] PROG_LO  = 16'hDC00;
  localparam logic [15:0] PROG_HI  = 16'hFBFF;
  localparam logic [15:0] MON_LO   = 16'hFE10;
  localparam logic [15:0] MON_HI   = 16'hFFCE;
  localparam logic [15:0] RSV_A    = 16'hFE08;
  localparam logic [15:0] RSV_B    = 16'hFFCF;
  localparam logic [15:0] OPT_ADDR = 16'hFFD0;
  localparam logic [15:0] VEC_LO   = 16'hFFDC;
  localparam logic [15:0] VEC_HI   = 16'hFFFF;
  // ==========================================================
  // store sizes in bytes
  localparam int          IO_BYTES   = 64;
  localparam int          PROG_BYTES = 8192;
  localparam int          VEC_BYTES  = 36;
  localparam int          MON_BYTES  = 447;
  // ==========================================================
  // fixed contents and answers
  localparam logic [7:0]  PROG_SEED  = 8'h5A;
  localparam logic [7:0]  VEC_SEED   = 8'hC3;
  localparam logic [7:0]  MON_SEED   = 8'h96;
  localparam logic [7:0]  OPT_VALUE  = 8'h00;
  localparam logic [7:0]  UNUSED_VAL = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  // ==========================================================
  // write channel state
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_ADDR = 2'b01,
    WS_DATA = 2'b10,
    WS_RESP = 2'b11
  } rvad_wstate_t;
endpackage : rvad_pkg

// [include/rvad_rom_if.sv]
// index and data between the decoder and one fixed store
`timescale 1ns/100ps
interface rvad_rom_if;
  logic [15:0] idx;
  logic [7:0]  data;
  modport reader (output idx, input data);
  modport store  (input idx, output data);
endinterface : rvad_rom_if

// [src/rvad_decoder.sv]
// axi4-lite slave decoding the cpu memory map of the rom variant
`timescale 1ns/100ps
// Operation
// [R1] Addresses DC00 to FBFF read an 8192-byte program store that writes cannot change.
// [R2] Addresses FFDC to FFFF read a 36-byte vector store with fixed contents.
// [R3] Addresses FE08 and FFCF are reserved, hold no register and accesses do nothing.
// [R4] The option byte at FFD0 answers reads only and writes leave it unchanged.
// [R5] The option byte value is a hard-wired constant, not programmable storage.
// [R6] Addresses FE10 to FFCE read the test-only monitor store with no programming routines.
// [R7] Addresses 0000 to 003F select the 64-byte on-chip i/o register page.
// [R8] Reserved and unused locations read a fixed constant and writes are dropped with no error.
module rvad_decoder #(
  parameter logic [7:0] OPTION_BYTE = rvad_pkg::OPT_VALUE
) (
  input  wire logic        ref_clk,       // bus clock
  input  wire logic        rst,           // synchronous reset, high
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte lanes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic             io_rd,         // i/o page read strobe
  output logic [5:0]       io_raddr,      // i/o page read offset
  input  wire logic [7:0]  io_rdata,      // i/o page read byte
  output logic             io_we,         // i/o page write strobe
  output logic [5:0]       io_waddr,      // i/o page write offset
  output logic [7:0]       io_wdata       // i/o page write byte
);
  // ==========================================================
  // read address decode
  logic [15:0] ra;
  logic        r_low;
  logic        r_io;
  logic        r_prog;
  logic        r_vec;
  logic        r_mon;
  logic        r_opt;
  logic [7:0]  rd_byte;
  logic        ar_hs;

  rvad_rom_if prog_if ();
  rvad_rom_if vec_if ();
  rvad_rom_if mon_if ();

  assign ra    = s_axi_araddr[15:0];
  assign r_low = (s_axi_araddr[31:16] == '0);
  // [R7] i/o page window
  assign r_io   = r_low && (ra <= rvad_pkg::IO_HI);
  // [R1] program store window
  assign r_prog = r_low && (ra >= rvad_pkg::PROG_LO) && (ra <= rvad_pkg::PROG_HI);
  // [R2] vector store window
  assign r_vec  = r_low && (ra >= rvad_pkg::VEC_LO);
  // [R6] monitor store window
  assign r_mon  = r_low && (ra >= rvad_pkg::MON_LO) && (ra <= rvad_pkg::MON_HI);
  // [R4] option byte, read side only
  assign r_opt  = r_low && (ra == rvad_pkg::OPT_ADDR);

  assign prog_if.idx = ra - rvad_pkg::PROG_LO;
  assign vec_if.idx  = ra - rvad_pkg::VEC_LO;
  assign mon_if.idx  = ra - rvad_pkg::MON_LO;

  rvad_rom #(.DEPTH(rvad_pkg::PROG_BYTES), .SEED(rvad_pkg::PROG_SEED)) u_prog (.rom(prog_if));
  rvad_rom #(.DEPTH(rvad_pkg::VEC_BYTES),  .SEED(rvad_pkg::VEC_SEED))  u_vec  (.rom(vec_if));
  rvad_rom #(.DEPTH(rvad_pkg::MON_BYTES),  .SEED(rvad_pkg::MON_SEED))  u_mon  (.rom(mon_if));

  // [R5] option value is a wired constant
  // [R3] [R8] reserved and unused fall through to the constant
  assign rd_byte = r_io   ? io_rdata :
                   r_prog ? prog_if.data :
                   r_vec  ? vec_if.data :
                   r_mon  ? mon_if.data :
                   r_opt  ? OPTION_BYTE : rvad_pkg::UNUSED_VAL;

  // ==========================================================
  // read channel, one outstanding read
  logic        rvalid_r;
  logic [31:0] rdata_r;

  assign s_axi_arready = !rvalid_r;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign io_rd         = ar_hs && r_io;
  assign io_raddr      = ra[5:0];
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  // [R8] never an error answer
  assign s_axi_rresp   = rvad_pkg::RESP_OKAY;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // write channel, address and data in either order
  rvad_pkg::rvad_wstate_t wstate_r;
  rvad_pkg::rvad_wstate_t wstate_nxt;
  logic [31:0] waddr_r;
  logic [31:0] waddr_nxt;
  logic [7:0]  wbyte_r;
  logic [7:0]  wbyte_nxt;
  logic        wlane_r;
  logic        wlane_nxt;
  logic        aw_hs;
  logic        w_hs;
  logic        w_io;
  logic        io_we_r;
  logic        io_we_nxt;
  logic [5:0]  io_waddr_r;
  logic [7:0]  io_wdata_r;

  assign s_axi_awready = (wstate_r == rvad_pkg::WS_IDLE) || (wstate_r == rvad_pkg::WS_DATA);
  assign s_axi_wready  = (wstate_r == rvad_pkg::WS_IDLE) || (wstate_r == rvad_pkg::WS_ADDR);
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign waddr_nxt     = aw_hs ? s_axi_awaddr : waddr_r;
  assign wbyte_nxt     = w_hs ? s_axi_wdata[7:0] : wbyte_r;
  assign wlane_nxt     = w_hs ? s_axi_wstrb[0] : wlane_r;
  assign s_axi_bvalid  = (wstate_r == rvad_pkg::WS_RESP);
  // [R8] writes anywhere complete with okay
  assign s_axi_bresp   = rvad_pkg::RESP_OKAY;

  // [R1] [R3] [R4] only the i/o page accepts a write
  assign w_io      = (waddr_nxt[31:16] == '0) && (waddr_nxt[15:0] <= rvad_pkg::IO_HI);
  assign io_we_nxt = (wstate_r != rvad_pkg::WS_RESP) && (wstate_nxt == rvad_pkg::WS_RESP)
                     && w_io && wlane_nxt;

  always_comb begin
    wstate_nxt = wstate_r;
    case (wstate_r)
      rvad_pkg::WS_IDLE: begin
        if (aw_hs && w_hs)
          wstate_nxt = rvad_pkg::WS_RESP;
        else if (aw_hs)
          wstate_nxt = rvad_pkg::WS_ADDR;
        else if (w_hs)
          wstate_nxt = rvad_pkg::WS_DATA;
      end
      rvad_pkg::WS_ADDR: begin
        if (w_hs)
          wstate_nxt = rvad_pkg::WS_RESP;
      end
      rvad_pkg::WS_DATA: begin
        if (aw_hs)
          wstate_nxt = rvad_pkg::WS_RESP;
      end
      default: begin
        if (s_axi_bready)
          wstate_nxt = rvad_pkg::WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wstate_r <= rvad_pkg::WS_IDLE;
      waddr_r  <= '0;
      wbyte_r  <= '0;
      wlane_r  <= 1'b0;
    end else begin
      wstate_r <= wstate_nxt;
      waddr_r  <= waddr_nxt;
      wbyte_r  <= wbyte_nxt;
      wlane_r  <= wlane_nxt;
    end
  end

  // [R7] forward accepted page writes as one-cycle strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_we_r    <= 1'b0;
      io_waddr_r <= '0;
      io_wdata_r <= '0;
    end else begin
      io_we_r <= io_we_nxt;
      if (io_we_nxt) begin
        io_waddr_r <= waddr_nxt[5:0];
        io_wdata_r <= wbyte_nxt;
      end
    end
  end

  assign io_we    = io_we_r;
  assign io_waddr = io_waddr_r;
  assign io_wdata = io_wdata_r;

  // ==========================================================
  // assertions
  // low byte of the vector base, for the wrap-free offset
  localparam logic [7:0] VEC_OFS = rvad_pkg::VEC_LO[7:0];

  property p_prog_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_prog) |=> (rvalid_r && rdata_r == {24'h000000,
        rvad_pkg::PROG_SEED ^ $past(s_axi_araddr[7:0])});
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("program byte wrong"); // [R1]

  property p_vec_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_vec) |=> (rdata_r[7:0] ==
        (rvad_pkg::VEC_SEED ^ ($past(s_axi_araddr[7:0]) - VEC_OFS)));
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("vector byte wrong"); // [R2]

  property p_rsv_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_low && (ra == rvad_pkg::RSV_A || ra == rvad_pkg::RSV_B))
        |=> (rdata_r == {24'h000000, rvad_pkg::UNUSED_VAL}) && !io_we_r;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved read not constant"); // [R3]

  property p_opt_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_opt) |=> (rdata_r == {24'h000000, OPTION_BYTE});
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option byte changed"); // [R5]

  property p_opt_write;
    @(posedge ref_clk) disable iff (rst)
      (s_axi_bvalid && waddr_r == {16'h0000, rvad_pkg::OPT_ADDR}) |-> !io_we_r;
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option write had effect"); // [R4]

  property p_mon_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_mon) |=> (rdata_r[7:0] ==
        (rvad_pkg::MON_SEED ^ (($past(s_axi_araddr[15:0]) - rvad_pkg::MON_LO) & 16'h00FF)));
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("monitor byte wrong"); // [R6]

  property p_io_read;
    @(posedge ref_clk) disable iff (rst)
      (ar_hs && r_io) |-> io_rd ##1 (rdata_r[7:0] == $past(io_rdata));
  endproperty
  a_io_read: assert property (p_io_read) else $error("io read not forwarded"); // [R7]

  property p_io_write_in_page;
    @(posedge ref_clk) disable iff (rst)
      io_we_r |-> s_axi_bvalid && (waddr_r[31:16] == '0) && (waddr_r[15:0] <= rvad_pkg::IO_HI);
  endproperty
  a_io_write_in_page: assert property (p_io_write_in_page) else $error("stray io write"); // [R7]

  property p_bresp_soon;
    @(posedge ref_clk) disable iff (rst)
      (wstate_r != rvad_pkg::WS_RESP && wstate_nxt == rvad_pkg::WS_RESP)
        |=> s_axi_bvalid && s_axi_bresp == rvad_pkg::RESP_OKAY;
  endproperty
  a_bresp_soon: assert property (p_bresp_soon) else $error("write answer late or error"); // [R8]

  property p_cov_prog;
    @(posedge ref_clk) disable iff (rst) ar_hs && r_prog;
  endproperty
  c_cov_prog: cover property (p_cov_prog);

  property p_cov_io_we;
    @(posedge ref_clk) disable iff (rst) io_we_r;
  endproperty
  c_cov_io_we: cover property (p_cov_io_we);

  property p_cov_data_first;
    @(posedge ref_clk) disable iff (rst) wstate_r == rvad_pkg::WS_DATA ##1 s_axi_bvalid;
  endproperty
  c_cov_data_first: cover property (p_cov_data_first);
endmodule : rvad_decoder

// [src/rvad_rom.sv]
// mask-programmed read-only store with hard-wired contents
`timescale 1ns/100ps
module rvad_rom #(
  parameter int         DEPTH = 64,
  parameter logic [7:0] SEED  = 8'h00
) (
  rvad_rom_if.store rom // index in, fixed byte out
);
  // contents are wired pattern, no write path exists at all
  assign rom.data = (int'(rom.idx) < DEPTH) ? (SEED ^ rom.idx[7:0]) : rvad_pkg::UNUSED_VAL;
endmodule : rvad_rom

// [verification/rvad_decoder_tb.sv]
// self-checking bench for the rom-variant address decoder
`timescale 1ns/100ps
module rvad_decoder_tb;
  localparam logic [7:0] OPT = 8'hA7;
  logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, seed, a;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, io_rd, io_we;
  logic [5:0] io_raddr, io_waddr;
  logic [7:0] io_rdata, io_wdata;
  logic [7:0] shadow [64];
  logic [34:0] exp_q [$];
  int error_cnt, n_compared, cyc;
  // ==========================================================
  // design and page model
  rvad_decoder #(.OPTION_BYTE(OPT)) rvad_decoder_i (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_rd(io_rd), .io_raddr(io_raddr),
    .io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));
  rvad_io_page_model rvad_io_page_model_i (.ref_clk(ref_clk), .io_rd(io_rd),
    .io_raddr(io_raddr), .io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr),
    .io_wdata(io_wdata));
  // ==========================================================
  // expectations from the memory map
  function automatic logic [7:0] exp_byte(input logic [31:0] x);
    logic [15:0] c;
    c = x[15:0];
    if (x[31:16] != 16'h0000) return rvad_pkg::UNUSED_VAL;
    if (c <= rvad_pkg::IO_HI) return shadow[c[5:0]];
    if (c >= rvad_pkg::PROG_LO && c <= rvad_pkg::PROG_HI)
      return rvad_pkg::PROG_SEED ^ 8'(c - rvad_pkg::PROG_LO);
    if (c >= rvad_pkg::VEC_LO) return rvad_pkg::VEC_SEED ^ 8'(c - rvad_pkg::VEC_LO);
    if (c >= rvad_pkg::MON_LO && c <= rvad_pkg::MON_HI)
      return rvad_pkg::MON_SEED ^ 8'(c - rvad_pkg::MON_LO);
    if (c == rvad_pkg::OPT_ADDR) return OPT;
    return rvad_pkg::UNUSED_VAL;
  endfunction : exp_byte
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // ==========================================================
  // bus master tasks; ready lines stay high throughout
  task automatic rd(input logic [31:0] x);
    exp_q.push_back({1'b0, rvad_pkg::RESP_OKAY, 24'h000000, exp_byte(x)});
    araddr  <= x;
    arvalid <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
  endtask : rd
  task automatic wr(input logic [31:0] x, input logic [31:0] d, input logic [3:0] s);
    exp_q.push_back({1'b1, rvad_pkg::RESP_OKAY, 32'h00000000});
    if (x <= 32'(rvad_pkg::IO_HI) && s[0]) shadow[x[5:0]] = d[7:0];
    awaddr  <= x;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask : wr
  task automatic final_report();
    if (exp_q.size() != 0) error_cnt++;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // response watcher
  task automatic chk(input logic [34:0] got);
    logic [34:0] e;
    n_compared++;
    if (exp_q.size() == 0) e = '1;
    else e = exp_q.pop_front();
    if (got !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  always @(posedge ref_clk) begin
    if (!rst && rvalid === 1'b1 && rready) chk({1'b0, rresp, rdata});
    if (!rst && bvalid === 1'b1 && bready) chk({1'b1, bresp, 32'h00000000});
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // main sequence
  initial begin
    {awvalid, wvalid, arvalid, awaddr, wdata, wstrb, araddr} = '0;
    {rst, bready, rready} = 3'b111;
    seed = 32'h00001D25;
    for (int i = 0; i < 64; i++) shadow[i] = 8'(i) ^ 8'hA5;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(32'h0000DC00);
    rd(32'h0000FBFF);
    rd(32'h0000FFDC);
    rd(32'h0000FFFF);
    rd(32'h0000FE10);
    rd(32'h0000FFCE);
    rd(32'h0000FE08);
    rd(32'h0000FFCF);
    rd(32'h0000FFD0);
    rd(32'h0000003F);
    rd(32'h00000040);
    rd(32'h0000FC00);
    rd(32'h0000FFDB);
    rd(32'h0001DC00);
    wr(32'h0000FFD0, 32'h000000FF, 4'hF);
    rd(32'h0000FFD0);
    wr(32'h0000DC00, 32'h000000FF, 4'hF);
    rd(32'h0000DC00);
    wr(32'h0000FE08, 32'h00000001, 4'hF);
    rd(32'h0000FE08);
    wr(32'h0000FFCF, 32'h00000055, 4'hF);
    rd(32'h0000FFCF);
    wr(32'h0000FFFF, 32'h00000012, 4'hF);
    rd(32'h0000FFFF);
    wr(32'h0000FE10, 32'h00000034, 4'hF);
    rd(32'h0000FE10);
    wr(32'h0000003F, 32'h0000003C, 4'h1);
    rd(32'h0000003F);
    wr(32'h00000000, 32'h00000077, 4'hE);
    rd(32'h00000000);
    repeat (60) begin
      seed = lfsr_next(seed);
      a = seed[8] ? {26'h0000000, seed[5:0]} : {16'h0000, seed[31:16]};
      if (seed[9]) wr(a, seed, {3'b000, seed[10]});
      rd(a);
    end
    // let the watcher take the last answer before the queue is judged
    repeat (2) @(posedge ref_clk);
    final_report();
  end
endmodule : rvad_decoder_tb

// [verification/rvad_io_page_model.sv]
// i/o register page model standing behind the decoder's page strobes
`timescale 1ns/100ps
module rvad_io_page_model (
  input  wire logic       ref_clk,  // bus clock
  input  wire logic       io_rd,    // page read strobe
  input  wire logic [5:0] io_raddr, // read offset
  output logic      [7:0] io_rdata, // read byte
  input  wire logic       io_we,    // page write strobe
  input  wire logic [5:0] io_waddr, // write offset
  input  wire logic [7:0] io_wdata  // write byte
);
  // ==========================================================
  // page storage
  logic [7:0] mem [64];
  logic [7:0] last_r;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hA5;
    last_r = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (io_we) mem[io_waddr] <= io_wdata;
    if (io_rd) last_r <= mem[io_raddr];
  end
  // unselected: inverse of last byte, so a read without strobe shows
  assign io_rdata = io_rd ? mem[io_raddr] : ~last_r;
endmodule : rvad_io_page_model
